// File: design/lcdm_core.sv
// display ram, pointer and subaddress logic, clock select and multiplex drive
`timescale 1ns/1ps
`default_nettype none
module lcdm_core (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic osc_ext_sel_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  input wire logic [2:0] strapped_subaddress_pins_i,
  input wire logic rx_valid_i,
  input wire lcdm_pkg::lcdm_rx_t rx_byte_i,
  output logic rx_ready_o,
  output logic scl_hold_o,
  output logic ack_o,
  output logic low_power_o,
  output logic bias_half_o,
  output logic [3:0] backplane_outputs_o,
  output logic [39:0] segment_outputs_o
);
  typedef enum logic {ST_IDLE, ST_WRITE} lcdm_fsm_t;

  typedef struct packed {
    lcdm_fsm_t fsm;
    lcdm_pkg::lcdm_mode_t mode;
    logic low_power;
    logic bias_half;
    logic bank_in;
    logic bank_out;
    logic cmd_phase;
    logic [5:0] ptr;
    logic [2:0] sub;
    logic [7:0] shreg;
    logic [3:0] bits_left;
    logic [39:0][3:0] ram;
    logic [39:0] shift;
    logic [39:0] latch;
    logic [1:0] phase;
    logic inv;
    logic [39:0] seg;
    logic [3:0] bp;
    logic ack;
    logic [7:0] osc_cnt;
    logic clk_out;
    logic clk_in_d;
    logic sync_drv;
  } lcdm_core_st_t;

  lcdm_core_st_t st_r;
  lcdm_core_st_t st_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] nphases(input lcdm_pkg::lcdm_mode_t m);
    unique case (m)
      lcdm_pkg::LCDM_STATIC: nphases = 3'h1;
      lcdm_pkg::LCDM_MUX2: nphases = 3'h2;
      lcdm_pkg::LCDM_MUX3: nphases = 3'h3;
      lcdm_pkg::LCDM_MUX4: nphases = 3'h4;
    endcase
  endfunction

  function automatic logic [1:0] next_phase(input lcdm_pkg::lcdm_mode_t m, input logic [1:0] p);
    next_phase = ({1'b0, p} >= nphases(m) - 3'h1) ? 2'h0 : p + 2'h1;
  endfunction

  // ram bit shown in a phase; banks only swap in static and 1:2
  function automatic logic [1:0] row_of(input lcdm_pkg::lcdm_mode_t m, input logic bo, input logic [1:0] p);
    row_of = p;
    if (bo && (m == lcdm_pkg::LCDM_STATIC || m == lcdm_pkg::LCDM_MUX2))
      row_of = p + lcdm_pkg::BANK_ALT_OFS;
  endfunction

  function automatic logic [39:0] ram_col(input logic [39:0][3:0] r, input logic [1:0] row);
    for (int s = 0; s < lcdm_pkg::NUM_SEG; s++)
      ram_col[s] = r[s][row];
  endfunction

  function automatic logic [3:0] bp_active(input lcdm_pkg::lcdm_mode_t m, input logic [1:0] p);
    unique case (m)
      lcdm_pkg::LCDM_STATIC: bp_active = 4'hf;
      lcdm_pkg::LCDM_MUX2: bp_active = (p == 2'h0) ? 4'h5 : 4'ha;
      lcdm_pkg::LCDM_MUX3: bp_active = (p == 2'h0) ? 4'h1 : (p == 2'h1) ? 4'ha : 4'h4;
      lcdm_pkg::LCDM_MUX4: bp_active = 4'h1 << p;
    endcase
  endfunction

  // ----------------------------------------
  // clock source and frame timing
  // ----------------------------------------
  logic osc_wrap;
  logic clk_tick;
  logic sync_restart;
  logic phase_tick;
  logic [11:0] frame_div;
  logic [11:0] phase_period;

  assign osc_wrap = (st_r.osc_cnt == lcdm_pkg::OSC_HALF_CYC - 8'h01);
  // external clock is an ordinary synchronous input; its rising edge is the tick
  assign clk_tick = osc_ext_sel_i ? (clk_pin_i && !st_r.clk_in_d) : (osc_wrap && !st_r.clk_out);
  assign sync_restart = clk_tick && !sync_i && !st_r.sync_drv;

  always_comb
  begin
    frame_div = st_r.low_power ? lcdm_pkg::FRAME_DIV_LOWPOW : lcdm_pkg::FRAME_DIV_NORMAL;
    unique case (st_r.mode)
      lcdm_pkg::LCDM_STATIC: phase_period = frame_div;
      lcdm_pkg::LCDM_MUX2: phase_period = frame_div >> 1;
      lcdm_pkg::LCDM_MUX3: phase_period = frame_div / 12'h003;
      lcdm_pkg::LCDM_MUX4: phase_period = frame_div >> 2;
    endcase
  end

  lcdm_phase_div u_div (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .tick_i(clk_tick),
    .restart_i(sync_restart),
    .period_i(phase_period),
    .pulse_o(phase_tick)
  );

  // ----------------------------------------
  // byte intake
  // ----------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  lcdm_pkg::lcdm_rx_t fifo_byte;
  logic take_byte;
  logic is_cmd;
  logic sub_match;

  lcdm_fifo #(
    .W(lcdm_pkg::RX_W),
    .DEPTH(lcdm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_byte_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_byte),
    .out_ready_i(fifo_ready)
  );

  // the writer drains one byte at a time, so a slow clock backs up the fifo
  assign fifo_ready = (st_r.fsm == ST_IDLE);
  assign scl_hold_o = rx_valid_i && !rx_ready_o;
  assign take_byte = fifo_valid && fifo_ready;
  assign is_cmd = fifo_byte.first || st_r.cmd_phase;
  assign sub_match = (st_r.sub == strapped_subaddress_pins_i);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [2:0] take;
  logic [1:0] ofs;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.clk_in_d = clk_pin_i;
    take = 3'h4;
    ofs = 2'h0;

    if (osc_wrap)
    begin
      st_nxt.osc_cnt = '0;
      st_nxt.clk_out = !st_r.clk_out;
    end
    else
      st_nxt.osc_cnt = st_r.osc_cnt + 8'h01;

    if (take_byte)
    begin
      if (is_cmd)
      begin
        st_nxt.cmd_phase = fifo_byte.data[lcdm_pkg::CMD_CONT_BIT];
        st_nxt.ack = 1'b1;
        if (fifo_byte.data[lcdm_pkg::CMD_PTR_BIT])
          st_nxt.ptr = fifo_byte.data[5:0];
        else
        begin
          unique case (fifo_byte.data[6:4])
            lcdm_pkg::OP_MODE:
            begin
              st_nxt.low_power = fifo_byte.data[lcdm_pkg::MODE_LOWPOW_BIT];
              st_nxt.bias_half = fifo_byte.data[lcdm_pkg::MODE_BIAS_BIT];
              st_nxt.mode = lcdm_pkg::lcdm_mode_t'(fifo_byte.data[1:0]);
            end
            lcdm_pkg::OP_DEVSEL: st_nxt.sub = fifo_byte.data[2:0];
            lcdm_pkg::OP_BANK:
            begin
              st_nxt.bank_in = fifo_byte.data[lcdm_pkg::BANK_IN_BIT];
              st_nxt.bank_out = fifo_byte.data[lcdm_pkg::BANK_OUT_BIT];
            end
            default: ;
          endcase
        end
      end
      else
      begin
        st_nxt.fsm = ST_WRITE;
        st_nxt.shreg = fifo_byte.data;
        st_nxt.bits_left = lcdm_pkg::BYTE_BITS;
        st_nxt.ack = sub_match;
      end
    end

    // one ram address per clock tick
    if (st_r.fsm == ST_WRITE && clk_tick)
    begin
      take = nphases(st_r.mode);
      if ({1'b0, take} > st_r.bits_left)
        take = st_r.bits_left[2:0];
      if (st_r.bank_in && (st_r.mode == lcdm_pkg::LCDM_STATIC || st_r.mode == lcdm_pkg::LCDM_MUX2))
        ofs = lcdm_pkg::BANK_ALT_OFS;
      for (int i = 0; i < 4; i++)
      begin
        // pointer above the last address stores nothing
        if (i < int'(take) && sub_match && st_r.ptr <= lcdm_pkg::RAM_LAST)
          st_nxt.ram[st_r.ptr][2'(i) + ofs] = st_r.shreg[7 - i];
      end
      st_nxt.shreg = st_r.shreg << take;
      st_nxt.bits_left = st_r.bits_left - 4'(take);
      // per-address stepping makes the byte step 8, 4, 3 or 2
      if (st_r.ptr >= lcdm_pkg::RAM_LAST)
      begin
        st_nxt.ptr = '0;
        st_nxt.sub = st_r.sub + 3'h1;
      end
      else
        st_nxt.ptr = st_r.ptr + 6'h01;
      if (st_r.bits_left == 4'(take))
        st_nxt.fsm = ST_IDLE;
    end

    // multiplex drive
    if (clk_tick)
      st_nxt.sync_drv = 1'b0;
    if (sync_restart)
      st_nxt.phase = 2'h0;
    else if (phase_tick)
    begin
      st_nxt.phase = next_phase(st_r.mode, st_r.phase);
      if (st_nxt.phase == 2'h0)
      begin
        st_nxt.inv = !st_r.inv;
        st_nxt.sync_drv = 1'b1;
      end
      // latch takes the prepared column, shift fetches the following one
      st_nxt.latch = st_r.shift;
      st_nxt.shift = ram_col(st_r.ram, row_of(st_r.mode, st_r.bank_out, next_phase(st_r.mode, st_nxt.phase)));
      st_nxt.seg = ~(st_r.shift ^ {40{st_nxt.inv}});
      st_nxt.bp = bp_active(st_r.mode, st_nxt.phase) ^ {4{st_nxt.inv}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
      st_r.mode <= lcdm_pkg::RST_MODE;
      st_r.ptr <= lcdm_pkg::RST_PTR;
      st_r.sub <= lcdm_pkg::RST_SUB;
      st_r.cmd_phase <= 1'b1;
      st_r.seg <= '1;
      st_r.bp <= '1;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign clk_pin_o = st_r.clk_out;
  assign clk_pin_oe_o = !osc_ext_sel_i;
  assign sync_o = 1'b0;
  assign sync_oe_o = st_r.sync_drv;
  assign ack_o = st_r.ack;
  assign low_power_o = st_r.low_power;
  assign bias_half_o = st_r.bias_half;
  assign backplane_outputs_o = st_r.bp;
  assign segment_outputs_o = st_r.seg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  logic wr_step;
  assign wr_step = (st_r.fsm == ST_WRITE) && clk_tick;

  property p_int_clk_toggle;
    !osc_ext_sel_i && osc_wrap |-> clk_pin_oe_o ##1 clk_pin_o != $past(clk_pin_o);
  endproperty
  a_int_clk_toggle: assert property (p_int_clk_toggle) else $error("internal clock not driven out");

  property p_ext_clk_in;
    osc_ext_sel_i |-> !clk_pin_oe_o && (clk_tick == (clk_pin_i && !$past(clk_pin_i)));
  endproperty
  a_ext_clk_in: assert property (p_ext_clk_in) else $error("external clock not used as input");

  // a full fifo in front of an idle writer frees one slot on the next edge
  property p_hold_scl;
    rx_valid_i && !rx_ready_o && fifo_ready |-> scl_hold_o ##1 rx_ready_o;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("serial clock not held while full");

  property p_ptr_step;
    wr_step && st_r.ptr < lcdm_pkg::RAM_LAST |=> st_r.ptr == $past(st_r.ptr) + 6'h01 && st_r.sub == $past(st_r.sub);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step by one address");

  property p_sub_carry;
    wr_step && st_r.ptr == lcdm_pkg::RAM_LAST |=> st_r.ptr == 6'h00 && st_r.sub == $past(st_r.sub) + 3'h1;
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subaddress did not carry on overflow");

  property p_no_write_mismatch;
    wr_step && !sub_match |=> st_r.ram == $past(st_r.ram);
  endproperty
  a_no_write_mismatch: assert property (p_no_write_mismatch) else $error("ram written on mismatch");

  property p_mux3_bit2_kept;
    wr_step && sub_match && st_r.mode == lcdm_pkg::LCDM_MUX3 && st_r.bits_left == 4'h2 && !st_r.ptr[5]
      |=> st_r.ram[$past(st_r.ptr)][2] == $past(st_r.ram[st_r.ptr][2]);
  endproperty
  a_mux3_bit2_kept: assert property (p_mux3_bit2_kept) else $error("bit 2 of third address changed");

  property p_latch_from_shift;
    phase_tick && !sync_restart |=> st_r.latch == $past(st_r.shift);
  endproperty
  a_latch_from_shift: assert property (p_latch_from_shift) else $error("latch not loaded from shift path");

  property p_bp_mux3;
    phase_tick && st_r.mode == lcdm_pkg::LCDM_MUX3 |=> backplane_outputs_o[3] == backplane_outputs_o[1];
  endproperty
  a_bp_mux3: assert property (p_bp_mux3) else $error("fourth backplane differs from second");

  property p_data_ack;
    take_byte && !is_cmd |=> ack_o == $past(sub_match) ##1 !ack_o;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data ack not tied to subaddress match");

  c_data_write: cover property (wr_step && sub_match);
  c_sub_carry: cover property (wr_step && st_r.ptr == lcdm_pkg::RAM_LAST);
  c_scl_hold: cover property (scl_hold_o);
  c_frame_wrap: cover property (phase_tick ##1 st_r.phase == 2'h0);
endmodule
`default_nettype wire

// File: design/lcdm_pkg.sv
// constants, types and shared encodings of the lcd display ram and multiplex core
package lcdm_pkg;

  typedef enum logic [1:0] {LCDM_STATIC, LCDM_MUX2, LCDM_MUX3, LCDM_MUX4} lcdm_mode_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } lcdm_rx_t;

  // ----------------------------------------
  // sizes and counts
  // ----------------------------------------
  localparam int NUM_SEG = 40;
  localparam int RX_W = 9;
  localparam int FIFO_DEPTH = 4;
  localparam logic [5:0] RAM_LAST = 6'h27;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [11:0] FRAME_DIV_NORMAL = 12'hb40;
  localparam logic [11:0] FRAME_DIV_LOWPOW = 12'h1e0;
  localparam logic [7:0] OSC_HALF_CYC = 8'h02;

  // ----------------------------------------
  // command byte layout
  // ----------------------------------------
  localparam int CMD_CONT_BIT = 7;
  localparam int CMD_PTR_BIT = 6;
  localparam logic [2:0] OP_MODE = 3'h0;
  localparam logic [2:0] OP_DEVSEL = 3'h1;
  localparam logic [2:0] OP_BANK = 3'h2;
  localparam int MODE_LOWPOW_BIT = 3;
  localparam int MODE_BIAS_BIT = 2;
  localparam int BANK_IN_BIT = 1;
  localparam int BANK_OUT_BIT = 0;
  localparam logic [1:0] BANK_ALT_OFS = 2'h2;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam lcdm_mode_t RST_MODE = LCDM_MUX4;
  localparam logic [5:0] RST_PTR = 6'h00;
  localparam logic [2:0] RST_SUB = 3'h0;

endpackage

// File: design/lcdm_fifo.sv
// small valid/ready byte fifo in front of the ram writer
`timescale 1ns/1ps
`default_nettype none
module lcdm_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } lcdm_fifo_st_t;

  lcdm_fifo_st_t st_r;
  lcdm_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (st_r.cnt != FULL);
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o = st_r.mem[st_r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = in_data_i;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule
`default_nettype wire

// File: design/lcdm_phase_div.sv
// divider turning clock ticks into multiplex phase pulses
`timescale 1ns/1ps
`default_nettype none
module lcdm_phase_div (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic [11:0] period_i,
  output logic pulse_o
);
  typedef struct packed {
    logic [11:0] cnt;
    logic pulse;
  } lcdm_div_st_t;

  lcdm_div_st_t st_r;
  lcdm_div_st_t st_nxt;

  assign pulse_o = st_r.pulse;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (restart_i)
      st_nxt.cnt = '0;
    else if (tick_i)
    begin
      // >= guards a shorter period chosen while the count is high
      if (st_r.cnt >= period_i - 12'h001)
      begin
        st_nxt.cnt = '0;
        st_nxt.pulse = 1'b1;
      end
      else
        st_nxt.cnt = st_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule
`default_nettype wire

// File: test/lcdm_host.sv
// host model offering command and display bytes to the core
`timescale 1ns/1ps
`default_nettype none
module lcdm_host (
  input wire logic clk_sys_i,
  input wire logic rx_ready_i,
  input wire logic scl_hold_i,
  output logic rx_valid_o,
  output lcdm_pkg::lcdm_rx_t rx_byte_o,
  output int holds_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_byte_o = '0;
    holds_o = 0;
  end
  // offer one byte and sit out any clock stretching
  task automatic put(input logic first, input logic [7:0] data);
    begin
      @(negedge clk_sys_i);
      rx_valid_o = 1'b1;
      rx_byte_o = '{first: first, data: data};
      #1;
      while (rx_ready_i !== 1'b1)
      begin
        if (scl_hold_i === 1'b1)
          holds_o++;
        @(negedge clk_sys_i);
        #1;
      end
      @(posedge clk_sys_i);
    end
  endtask
  // released lines show the inverse, not a stale byte
  task automatic idle();
    begin
      @(negedge clk_sys_i);
      rx_valid_o = 1'b0;
      rx_byte_o = ~rx_byte_o;
    end
  endtask
endmodule
`default_nettype wire

// File: test/tb_lcd_display_ram_mux_core.sv
// self-checking bench of the display ram and multiplex core
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_display_ram_mux_core;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic osc_ext_sel_i = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_run = 1'b0;
  logic [2:0] strap_v = 3'h0;
  logic rx_valid, rx_ready, scl_hold, ack, clk_o, clk_oe, sync_o, sync_oe, lp, bh;
  lcdm_pkg::lcdm_rx_t rx_byte;
  logic [3:0] bp;
  logic [39:0] seg;
  wire logic clk_pin = clk_oe ? clk_o : ext_clk;
  wire logic sync_pin = ~sync_oe;
  int fails = 0;
  int checks_done = 0;
  int seed = 77;
  int holds, ack_cnt = 0, exp_acks = 0, ptr = 0, sub = 0, strap = 0, mode = 3;
  int cyc = 0, last_rise = 0, gap = 0;
  logic sync_q = 1'b0;
  logic bank_in = 1'b0, bank_out = 1'b0;
  logic [3:0] ram [40];
  logic [7:0] cq [$];
  logic [7:0] dq [$];
  lcdm_core u_lcdm_core (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .osc_ext_sel_i(osc_ext_sel_i),
    .clk_pin_i(clk_pin), .clk_pin_o(clk_o), .clk_pin_oe_o(clk_oe), .sync_i(sync_pin), .sync_o(sync_o),
    .sync_oe_o(sync_oe), .strapped_subaddress_pins_i(strap_v), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte),
    .rx_ready_o(rx_ready), .scl_hold_o(scl_hold), .ack_o(ack), .low_power_o(lp), .bias_half_o(bh),
    .backplane_outputs_o(bp), .segment_outputs_o(seg));
  lcdm_host u_lcdm_host (.clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready), .scl_hold_i(scl_hold),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .holds_o(holds));
  // clock never stops, the panel must not sit in dc
  always #10 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i)
    if (ext_run)
      ext_clk <= ~ext_clk;
  always @(negedge clk_sys_i)
  begin
    cyc++;
    if (ack === 1'b1)
      ack_cnt++;
    if (sync_oe === 1'b1 && sync_q !== 1'b1)
    begin
      gap = cyc - last_rise;
      last_rise = cyc;
    end
    sync_q = sync_oe;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    begin
      checks_done++;
      if (got !== exp)
      begin
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic test_done();
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // reference store: mode+1 bits per address, msb first, bank offset only in static and 1:2
  task automatic store(input logic [7:0] b);
    int k, n;
    begin
      if (sub == strap)
        exp_acks++;
      k = 7;
      while (k >= 0)
      begin
        for (n = 0; n <= mode && k >= 0; n++)
        begin
          if (sub == strap && ptr < 40)
            ram[ptr][n + ((bank_in && mode < 2) ? 2 : 0)] = b[k];
          k--;
        end
        ptr++;
        if (ptr > 39)
        begin
          ptr = 0;
          sub = (sub + 1) % 8;
        end
      end
    end
  endtask
  task automatic xfer();
    int i;
    begin
      for (i = 0; i < cq.size(); i++)
      begin
        u_lcdm_host.put(i == 0, cq[i] | ((i < cq.size() - 1) ? 8'h80 : 8'h00));
        exp_acks++;
        if (cq[i][6])
          ptr = cq[i][5:0];
        else if (cq[i][6:4] == 3'h1)
          sub = cq[i][2:0];
        else if (cq[i][6:4] == 3'h2)
          {bank_in, bank_out} = cq[i][1:0];
        else if (cq[i][6:4] == 3'h0)
          mode = cq[i][1:0];
      end
      foreach (dq[j])
      begin
        u_lcdm_host.put(1'b0, dq[j]);
        store(dq[j]);
      end
      u_lcdm_host.idle();
      i = 0;
      while (ack_cnt != exp_acks && i < 4000)
      begin
        @(negedge clk_sys_i);
        i++;
      end
      repeat (60) @(negedge clk_sys_i);
      chk(ack_cnt, exp_acks);
    end
  endtask
  task automatic show();
    logic [39:0] e;
    int i;
    begin
      repeat (2200) @(negedge clk_sys_i);
      for (i = 0; i < 40; i++)
        e[i] = ram[i][bank_out ? 2 : 0] ? ~bp[0] : bp[0];
      chk(seg, e);
      chk(bp, {4{bp[0]}});
    end
  endtask
  task automatic rnd(input int n);
    begin
      dq = {};
      repeat (n) dq.push_back(8'($random(seed)));
    end
  endtask
  // in 1:4 the odd backplane names the row, and the level of the other three is the frame polarity
  task automatic peek();
    logic [39:0] e;
    logic v;
    int i, r;
    begin
      repeat (500) @(negedge clk_sys_i);
      repeat (8)
      begin
        repeat (250) @(negedge clk_sys_i);
        v = (bp[0] + bp[1] + bp[2] + bp[3]) > 1;
        r = 0;
        for (i = 0; i < 4; i++)
          if (bp[i] !== v)
            r = i;
        chk(bp ^ {4{v}}, 4'h1 << r);
        for (i = 0; i < 40; i++)
          e[i] = ram[i][r] ? v : ~v;
        chk(seg, e);
      end
    end
  endtask
  initial
  begin
    #1_000_000;
    fails++;
    test_done();
  end
  initial
  begin
    strap_v = 3'($random(seed));
    strap = strap_v;
    foreach (ram[i])
      ram[i] = 4'h0;
    repeat (5) @(negedge clk_sys_i);
    chk({seg, bp, ack}, {40'hff_ffff_ffff, 4'hf, 1'b0});
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({lp, bh}, 2'h0);
    chk(clk_oe, 1'b1);
    begin : toggles
      int n;
      logic prev;
      n = 0;
      prev = clk_o;
      repeat (40)
      begin
        @(negedge clk_sys_i);
        n += (clk_o !== prev);
        prev = clk_o;
      end
      chk(n, 40 / lcdm_pkg::OSC_HALF_CYC);
    end
    osc_ext_sel_i = 1'b1;
    ext_run = 1'b1;
    #1;
    chk(clk_oe, 1'b0);
    // six bytes back to back overrun the four-deep fifo behind a busy writer
    cq = '{8'h08, 8'h10 | strap_v, 8'h40};
    rnd(6);
    xfer();
    chk(holds > 0, 1'b1);
    show();
    chk(gap, 2 * 480);
    // wrong device until the pointer wraps mid byte
    cq = '{8'h10 | 3'(strap + 7), 8'h40 | 8'h24};
    dq = '{8'($random(seed))};
    xfer();
    show();
    cq = '{8'h10 | strap_v, 8'h22, 8'h40};
    rnd(6);
    xfer();
    show();
    cq = '{8'h23};
    dq = {};
    xfer();
    show();
    cq = '{8'h00};
    xfer();
    chk({lp, bh}, 2'h0);
    repeat (3 * 5760) @(negedge clk_sys_i);
    chk(gap, 2 * 2880);
    cq = '{8'h0d};
    xfer();
    chk({lp, bh}, 2'h3);
    repeat (4)
    begin
      repeat (300) @(negedge clk_sys_i);
      chk({bp[2], bp[3]}, {bp[0], bp[1]});
    end
    cq = '{8'h0a};
    xfer();
    repeat (4)
    begin
      repeat (300) @(negedge clk_sys_i);
      chk(bp[3], bp[1]);
    end
    // 1:3 bytes from address 38 of the previous device carry into this one mid byte
    cq = '{8'h0a, 8'h10 | 3'(strap + 7), 8'h40 | 8'h26};
    rnd(6);
    xfer();
    cq = '{8'h09, 8'h22, 8'h40 | 8'h10};
    rnd(3);
    xfer();
    cq = '{8'h0b, 8'h40 | 8'h20};
    rnd(2);
    xfer();
    peek();
    test_done();
  end
endmodule
`default_nettype wire
